// *** logic/crc_unit_consts.svh ***
// Contract
// - Clear-result zeroes the whole 32-bit result register in one cycle, flags kept.
// - Result-to-CPU move copies all 32 result bits out, taking two cycles.
// - CPU-to-result move writes the full 32-bit value, taking two cycles.
// - CRC24 low byte folds word bits 7:0 into result 23:0, fixed polynomial, one cycle.
// - CRC24 high byte folds word bits 15:8 into result 23:0, fixed polynomial, one cycle.
// - Reverse bit set bit-reverses the selected input field; clear uses it unchanged.
// - Low immediate load writes polynomial 15:0 and zeroes 31:16, one cycle.
// - High immediate load writes polynomial 31:16, keeps 15:0, one cycle.
// - Half write to data-width half replaces only that half, one cycle.
// - Half write to polynomial-width half replaces only that half, one cycle.
// - Set-widths loads 3-bit data width and 5-bit polynomial width from second word.
// - Generic low CRC uses field from bit 0, programmable polynomial and width, three cycles.
// - Generic high CRC is the same but the field starts at bit 8, three cycles.
// - Byte swap exchanges result 15:8 with 7:0, keeps 31:16, one cycle.
// - 32-bit memory move loads the whole polynomial register in one cycle.
// - 32-bit memory move loads the whole size register, both halves, one cycle.
// - 32-bit move stores the whole polynomial register to memory in one cycle.
// - 32-bit move stores the whole size register to memory in one cycle.
// - No instruction of this unit alters any other status flag.
// - Set-reverse and clear-reverse set and clear the reverse bit, one cycle each.
`ifndef CRC_UNIT_CONSTS_SVH
`define CRC_UNIT_CONSTS_SVH

// ----------------------------------------------------------------
// First opcode word values
// ----------------------------------------------------------------
`define OPW_CLEAR_RESULT 16'hE524
`define OPW_BYTE_SWAP 16'hE52E
`define OPW_SET_REVERSE 16'hE52C
`define OPW_CLEAR_REVERSE 16'hE52D
`define OPW_POLY_LOW_IMM 16'hE754
`define OPW_POLY_HIGH_IMM 16'hE755
`define OPW_SET_WIDTHS 16'hE756
`define OPW_MEM16_GROUP 16'hE2CB
`define OPW_LOAD32_GROUP 16'hE3F2
`define OPW_STORE32_GROUP 16'hE206
`define OPB_RESULT_TO_CPU 8'hBF
`define OPB_CPU_TO_RESULT 8'hBD

// ----------------------------------------------------------------
// Second opcode word selector (bits 15:8)
// ----------------------------------------------------------------
`define SEL_CRC24_LOW 8'h01
`define SEL_CRC24_HIGH 8'h02
`define SEL_PWIDTH_HALF 8'h04
`define SEL_DWIDTH_HALF 8'h05
`define SEL_GENERIC_LOW 8'h06
`define SEL_GENERIC_HIGH 8'h07
`define SEL_POLY32 8'h00
`define SEL_SIZE32 8'h02
`define SEL_POLY32_ST 8'h01

// ----------------------------------------------------------------
// Fields, constants, reset values, timing
// ----------------------------------------------------------------
`define CRC24_POLY 32'h005D6DCB
`define CRC24_PWIDTH 5'h17
`define BYTE_DWIDTH 3'h7
`define DWIDTH_LSB 16
`define DWIDTH_MSB 18
`define PWIDTH_LSB 0
`define PWIDTH_MSB 4
`define SETW_D_MSB 10
`define SETW_D_LSB 8
`define SETW_P_MSB 4
`define SETW_P_LSB 0
`define RESULT_RESET 32'h00000000
`define POLY_RESET 32'h00000000
`define SIZE_RESET 32'h00000000
`define MOVE_CYCLES 2
`define GENERIC_CYCLES 3
`define STORE_FIFO_DEPTH 8

`endif

// *** logic/crc_unit_pkg.sv ***
`default_nettype none

package crc_unit_pkg;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_CLEAR_RESULT = 5'h01,
    OP_RESULT_TO_CPU = 5'h02,
    OP_CPU_TO_RESULT = 5'h03,
    OP_CRC24_LOW = 5'h04,
    OP_CRC24_HIGH = 5'h05,
    OP_POLY_LOW_IMM = 5'h06,
    OP_POLY_HIGH_IMM = 5'h07,
    OP_DWIDTH_HALF = 5'h08,
    OP_PWIDTH_HALF = 5'h09,
    OP_SET_WIDTHS = 5'h0A,
    OP_GENERIC_LOW = 5'h0B,
    OP_GENERIC_HIGH = 5'h0C,
    OP_BYTE_SWAP = 5'h0D,
    OP_POLY_FROM_MEM = 5'h0E,
    OP_SIZE_FROM_MEM = 5'h0F,
    OP_POLY_TO_MEM = 5'h10,
    OP_SIZE_TO_MEM = 5'h11,
    OP_SET_REVERSE = 5'h12,
    OP_CLEAR_REVERSE = 5'h13
  } crc_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } ctrl_state_t;

endpackage : crc_unit_pkg

`default_nettype wire

// *** logic/crc_store_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module crc_store_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic in_valid_i, // Push request
  output logic in_ready_o, // Not full
  input wire logic [WIDTH-1:0] in_data_i, // Push data
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i, // Pop request
  output logic [WIDTH-1:0] out_data_o // Head word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule : crc_store_fifo

`default_nettype wire

// *** logic/crc_lfsr_step.sv ***
`timescale 1ns/1ps
`default_nettype none

module crc_lfsr_step (
  input wire logic [31:0] crc_i, // Running result
  input wire logic [31:0] poly_i, // Polynomial
  input wire logic [4:0] pwidth_i, // Top bit index of CRC
  input wire logic [2:0] dwidth_i, // Top bit index of field
  input wire logic [7:0] field_i, // Field, MSB left-aligned at bit 7
  output logic [31:0] crc_o // Updated result
);

  // --------------------------------------------------------------
  // Serial update, one field bit per step
  // --------------------------------------------------------------
  always_comb begin
    logic [31:0] c;
    logic [31:0] keep;
    logic fb;
    c = crc_i;
    keep = 32'hFFFFFFFF << pwidth_i;
    keep = keep << 1;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(dwidth_i)) begin
        fb = c[pwidth_i] ^ field_i[7-i];
        c = ((c << 1) & ~keep) | (crc_i & keep);
        if (fb) begin
          c = c ^ (poly_i & ~keep);
        end
      end
    end
    crc_o = c;
  end

endmodule : crc_lfsr_step

`default_nettype wire

// *** logic/crc_coprocessor_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crc_unit_consts.svh"

module crc_coprocessor_unit #(
  parameter int STORE_DEPTH = `STORE_FIFO_DEPTH
) (
  input wire logic clk_i, // CPU clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic op_valid_i, // Instruction offered
  output logic op_ready_o, // Instruction taken this cycle
  input wire logic [15:0] op_lsw_i, // First opcode word
  input wire logic [15:0] op_msw_i, // Second opcode word or immediate
  input wire logic [31:0] op_data_i, // Operand value from memory or CPU
  output logic op_done_o, // Instruction finished, pulse
  output logic st_valid_o, // Store word available
  input wire logic st_ready_i, // Store word consumed
  output logic [31:0] st_data_o, // Store word
  output logic [31:0] crc_result_o, // Result register
  output logic [31:0] crc_poly_o, // Polynomial register
  output logic [31:0] crc_size_o, // Size register
  output logic msg_bit_reverse_o, // Reverse bit of status
  output logic busy_o // Multi-cycle instruction running
);

  import crc_unit_pkg::*;

  logic [31:0] crc_result_reg;
  logic [31:0] crc_poly_reg;
  logic [31:0] crc_size_reg;
  logic msg_bit_reverse_reg;
  ctrl_state_t state_reg;
  logic [1:0] cnt_reg;
  crc_op_t op_reg;
  logic [31:0] data_reg;
  logic done_reg;

  crc_op_t op_dec;
  crc_op_t exec_op;
  logic [31:0] exec_data;
  logic exec_en;
  logic accept;
  logic finish;
  logic is_store;
  logic is_multi;
  logic fifo_ready;
  logic push;
  logic [31:0] push_data;

  // --------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------
  always_comb begin
    op_dec = OP_NONE;
    if (op_lsw_i[15:8] == `OPB_RESULT_TO_CPU) begin
      op_dec = OP_RESULT_TO_CPU;
    end else if (op_lsw_i[15:8] == `OPB_CPU_TO_RESULT) begin
      op_dec = OP_CPU_TO_RESULT;
    end else begin
      unique case (op_lsw_i)
        `OPW_CLEAR_RESULT: op_dec = OP_CLEAR_RESULT;
        `OPW_BYTE_SWAP: op_dec = OP_BYTE_SWAP;
        `OPW_SET_REVERSE: op_dec = OP_SET_REVERSE;
        `OPW_CLEAR_REVERSE: op_dec = OP_CLEAR_REVERSE;
        `OPW_POLY_LOW_IMM: op_dec = OP_POLY_LOW_IMM;
        `OPW_POLY_HIGH_IMM: op_dec = OP_POLY_HIGH_IMM;
        `OPW_SET_WIDTHS: op_dec = OP_SET_WIDTHS;
        `OPW_MEM16_GROUP: begin
          unique case (op_msw_i[15:8])
            `SEL_CRC24_LOW: op_dec = OP_CRC24_LOW;
            `SEL_CRC24_HIGH: op_dec = OP_CRC24_HIGH;
            `SEL_PWIDTH_HALF: op_dec = OP_PWIDTH_HALF;
            `SEL_DWIDTH_HALF: op_dec = OP_DWIDTH_HALF;
            `SEL_GENERIC_LOW: op_dec = OP_GENERIC_LOW;
            `SEL_GENERIC_HIGH: op_dec = OP_GENERIC_HIGH;
            default: op_dec = OP_NONE;
          endcase
        end
        `OPW_LOAD32_GROUP: begin
          unique case (op_msw_i[15:8])
            `SEL_POLY32: op_dec = OP_POLY_FROM_MEM;
            `SEL_SIZE32: op_dec = OP_SIZE_FROM_MEM;
            default: op_dec = OP_NONE;
          endcase
        end
        `OPW_STORE32_GROUP: begin
          unique case (op_msw_i[15:8])
            `SEL_POLY32_ST: op_dec = OP_POLY_TO_MEM;
            `SEL_SIZE32: op_dec = OP_SIZE_TO_MEM;
            default: op_dec = OP_NONE;
          endcase
        end
        default: op_dec = OP_NONE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Issue control
  // --------------------------------------------------------------
  assign is_store = (op_dec == OP_RESULT_TO_CPU) || (op_dec == OP_POLY_TO_MEM) || (op_dec == OP_SIZE_TO_MEM);
  assign is_multi = (op_dec == OP_RESULT_TO_CPU) || (op_dec == OP_CPU_TO_RESULT) ||
                    (op_dec == OP_GENERIC_LOW) || (op_dec == OP_GENERIC_HIGH);
  // Stores wait for room so the store word is never dropped
  assign op_ready_o = (state_reg == ST_IDLE) && (!is_store || fifo_ready);
  assign accept = op_valid_i && op_ready_o;
  assign finish = (state_reg == ST_BUSY) && (cnt_reg == 2'h0);
  assign exec_en = (accept && !is_multi) || finish;
  assign exec_op = (state_reg == ST_BUSY) ? op_reg : op_dec;
  assign exec_data = (state_reg == ST_BUSY) ? data_reg : op_data_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      op_reg <= OP_NONE;
      data_reg <= 32'h00000000;
    end else if (accept && is_multi) begin
      state_reg <= ST_BUSY;
      op_reg <= op_dec;
      data_reg <= op_data_i;
      if ((op_dec == OP_GENERIC_LOW) || (op_dec == OP_GENERIC_HIGH)) begin
        cnt_reg <= 2'(`GENERIC_CYCLES - 2);
      end else begin
        cnt_reg <= 2'(`MOVE_CYCLES - 2);
      end
    end else if (finish) begin
      state_reg <= ST_IDLE;
    end else if (state_reg == ST_BUSY) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= exec_en;
    end
  end

  // --------------------------------------------------------------
  // Input field selection and CRC datapath
  // --------------------------------------------------------------
  logic high_sel;
  logic is_crc24;
  logic [7:0] raw_byte;
  logic [7:0] rev_byte;
  logic [7:0] field;
  logic [2:0] dwidth;
  logic [4:0] pwidth;
  logic [31:0] poly;
  logic [31:0] crc_next;

  assign is_crc24 = (exec_op == OP_CRC24_LOW) || (exec_op == OP_CRC24_HIGH);
  assign high_sel = (exec_op == OP_CRC24_HIGH) || (exec_op == OP_GENERIC_HIGH);
  assign raw_byte = high_sel ? exec_data[15:8] : exec_data[7:0];
  assign dwidth = is_crc24 ? `BYTE_DWIDTH : crc_size_reg[`DWIDTH_MSB:`DWIDTH_LSB];
  assign pwidth = is_crc24 ? `CRC24_PWIDTH : crc_size_reg[`PWIDTH_MSB:`PWIDTH_LSB];
  assign poly = is_crc24 ? `CRC24_POLY : crc_poly_reg;

  generate
    for (genvar b = 0; b < 8; b++) begin : g_rev
      assign rev_byte[b] = raw_byte[7-b];
    end
  endgenerate

  // Flipped field: its low bit enters first; both cases left-aligned
  always_comb begin
    if (msg_bit_reverse_reg) begin
      field = rev_byte;
    end else begin
      field = raw_byte << (3'h7 - dwidth);
    end
  end

  crc_lfsr_step u_lfsr (
    .crc_i(crc_result_reg),
    .poly_i(poly),
    .pwidth_i(pwidth),
    .dwidth_i(dwidth),
    .field_i(field),
    .crc_o(crc_next)
  );

  // --------------------------------------------------------------
  // Result register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      crc_result_reg <= `RESULT_RESET;
    end else if (exec_en) begin
      unique case (exec_op)
        OP_CLEAR_RESULT: crc_result_reg <= 32'h00000000;
        OP_CPU_TO_RESULT: crc_result_reg <= exec_data;
        OP_CRC24_LOW, OP_CRC24_HIGH: crc_result_reg <= crc_next;
        OP_GENERIC_LOW, OP_GENERIC_HIGH: crc_result_reg <= crc_next;
        OP_BYTE_SWAP: crc_result_reg <= {crc_result_reg[31:16], crc_result_reg[7:0], crc_result_reg[15:8]};
        default: crc_result_reg <= crc_result_reg;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Polynomial register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      crc_poly_reg <= `POLY_RESET;
    end else if (exec_en) begin
      unique case (exec_op)
        OP_POLY_LOW_IMM: crc_poly_reg <= {16'h0000, op_msw_i};
        OP_POLY_HIGH_IMM: crc_poly_reg <= {op_msw_i, crc_poly_reg[15:0]};
        OP_POLY_FROM_MEM: crc_poly_reg <= exec_data;
        default: crc_poly_reg <= crc_poly_reg;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Size register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      crc_size_reg <= `SIZE_RESET;
    end else if (exec_en) begin
      unique case (exec_op)
        OP_DWIDTH_HALF: crc_size_reg <= {exec_data[15:0], crc_size_reg[15:0]};
        OP_PWIDTH_HALF: crc_size_reg <= {crc_size_reg[31:16], exec_data[15:0]};
        OP_SET_WIDTHS: begin
          crc_size_reg <= {13'h0000, op_msw_i[`SETW_D_MSB:`SETW_D_LSB], 11'h000,
                           op_msw_i[`SETW_P_MSB:`SETW_P_LSB]};
        end
        OP_SIZE_FROM_MEM: crc_size_reg <= exec_data;
        default: crc_size_reg <= crc_size_reg;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Status: only the reverse bit is ever touched
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      msg_bit_reverse_reg <= 1'b0;
    end else if (exec_en && (exec_op == OP_SET_REVERSE)) begin
      msg_bit_reverse_reg <= 1'b1;
    end else if (exec_en && (exec_op == OP_CLEAR_REVERSE)) begin
      msg_bit_reverse_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Store path
  // --------------------------------------------------------------
  always_comb begin
    push = 1'b0;
    push_data = 32'h00000000;
    if (exec_en) begin
      unique case (exec_op)
        OP_RESULT_TO_CPU: begin
          push = 1'b1;
          push_data = crc_result_reg;
        end
        OP_POLY_TO_MEM: begin
          push = 1'b1;
          push_data = crc_poly_reg;
        end
        OP_SIZE_TO_MEM: begin
          push = 1'b1;
          push_data = crc_size_reg;
        end
        default: begin
          push = 1'b0;
          push_data = 32'h00000000;
        end
      endcase
    end
  end

  crc_store_fifo #(
    .WIDTH(32),
    .DEPTH(STORE_DEPTH)
  ) u_store_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(st_valid_o),
    .out_ready_i(st_ready_i),
    .out_data_o(st_data_o)
  );

  assign op_done_o = done_reg;
  assign crc_result_o = crc_result_reg;
  assign crc_poly_o = crc_poly_reg;
  assign crc_size_o = crc_size_reg;
  assign msg_bit_reverse_o = msg_bit_reverse_reg;
  assign busy_o = (state_reg == ST_BUSY);

endmodule : crc_coprocessor_unit

`default_nettype wire

// *** verification/crc_unit_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crc_unit_consts.svh"

module crc_unit_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic op_valid_i, // Offer
  input wire logic op_ready_o, // Taken
  input wire logic [15:0] op_lsw_i, // Word 1
  input wire logic [15:0] op_msw_i, // Word 2
  input wire logic [31:0] op_data_i, // Operand
  input wire logic op_done_o, // Done
  input wire logic st_valid_o, // Store valid
  input wire logic st_ready_i, // Store pop
  input wire logic [31:0] st_data_o, // Store word
  input wire logic [31:0] crc_result_o, // Result
  input wire logic [31:0] crc_poly_o, // Polynomial
  input wire logic [31:0] crc_size_o, // Size
  input wire logic msg_bit_reverse_o, // Reverse bit
  input wire logic busy_o // Busy
);
  logic tk;
  logic gen;
  logic m16;
  logic [31:0] swp;
  logic [15:0] plo;
  logic [15:0] slo;
  logic [15:0] dlo;
  assign tk = op_valid_i && op_ready_o;
  assign m16 = tk && op_lsw_i == `OPW_MEM16_GROUP;
  assign gen = m16 && (op_msw_i[15:8] == `SEL_GENERIC_LOW || op_msw_i[15:8] == `SEL_GENERIC_HIGH);
  assign swp = {crc_result_o[31:16], crc_result_o[7:0], crc_result_o[15:8]};
  assign plo = crc_poly_o[15:0];
  assign slo = crc_size_o[15:0];
  assign dlo = op_data_i[15:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------
  // Single- and multi-cycle steps
  // ------------------------------
  sequence hold_busy; (busy_o && !op_ready_o) [*2]; endsequence
  sequence end_gen; op_done_o && !busy_o; endsequence
  AST_CLEAR: assert property (tk && op_lsw_i == `OPW_CLEAR_RESULT |=> crc_result_o == 32'h0 && op_done_o)
    else $error("clear did not zero result");
  AST_TO_CPU: assert property (tk && op_lsw_i[15:8] == `OPB_RESULT_TO_CPU && !st_valid_o |=>
    busy_o ##1 (op_done_o && st_valid_o && st_data_o == $past(crc_result_o, 2)))
    else $error("result move out wrong");
  AST_FROM_CPU: assert property (tk && op_lsw_i[15:8] == `OPB_CPU_TO_RESULT |=>
    busy_o ##1 (op_done_o && crc_result_o == $past(op_data_i, 2)))
    else $error("result move in wrong");
  AST_POLY_LOW: assert property (tk && op_lsw_i == `OPW_POLY_LOW_IMM |=>
    crc_poly_o == {16'h0000, $past(op_msw_i)})
    else $error("low immediate load wrong");
  AST_POLY_HIGH: assert property (tk && op_lsw_i == `OPW_POLY_HIGH_IMM |=>
    crc_poly_o == {$past(op_msw_i), $past(plo)})
    else $error("high immediate load wrong");
  AST_DW_HALF: assert property (m16 && op_msw_i[15:8] == `SEL_DWIDTH_HALF |=>
    crc_size_o == {$past(dlo), $past(slo)})
    else $error("data width half write wrong");
  AST_GENERIC: assert property (gen |=> hold_busy ##1 end_gen)
    else $error("generic crc timing wrong");
  AST_SWAP: assert property (tk && op_lsw_i == `OPW_BYTE_SWAP |=> crc_result_o == $past(swp))
    else $error("byte swap wrong");
  AST_REV_SET: assert property (tk && op_lsw_i[15:1] == 15'h7296 |=> msg_bit_reverse_o == !$past(op_lsw_i[0]))
    else $error("reverse bit not updated");
  AST_REV_KEEP: assert property (!(tk && op_lsw_i[15:1] == 15'h7296) |=> $stable(msg_bit_reverse_o))
    else $error("status bit changed");
endmodule : crc_unit_asserts

bind crc_coprocessor_unit crc_unit_asserts u_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
  .op_ready_o(op_ready_o), .op_lsw_i(op_lsw_i), .op_msw_i(op_msw_i), .op_data_i(op_data_i), .op_done_o(op_done_o),
  .st_valid_o(st_valid_o), .st_ready_i(st_ready_i), .st_data_o(st_data_o), .crc_result_o(crc_result_o),
  .crc_poly_o(crc_poly_o), .crc_size_o(crc_size_o), .msg_bit_reverse_o(msg_bit_reverse_o), .busy_o(busy_o));

`default_nettype wire

// *** verification/crc_store_sink.sv ***
`timescale 1ns/1ps
`default_nettype none

module crc_store_sink (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic st_valid_i, // Word offered
  input wire logic [31:0] st_data_i, // Word
  input wire logic stall_i, // Hold off
  output logic st_ready_o // Pop
);
  logic [31:0] got[$];
  // Random stalls so the store path sees slow and prompt takers
  always_ff @(negedge clk_i) begin
    if (!rst_n_i) begin
      st_ready_o <= 1'b0;
    end else begin
      st_ready_o <= !stall_i && ($urandom_range(3) != 0);
    end
  end
  always @(posedge clk_i) begin
    if (rst_n_i && st_valid_i && st_ready_o) begin
      got.push_back(st_data_i);
    end
  end
endmodule : crc_store_sink

`default_nettype wire

// *** verification/test_crc_coprocessor_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_crc_coprocessor_unit;
  logic clk_i, rst_n_i, op_valid_i, op_ready_o, op_done_o, st_valid_o, st_ready_i, msg_bit_reverse_o, busy_o, stall;
  logic [15:0] op_lsw_i, op_msw_i;
  logic [31:0] op_data_i, st_data_o, crc_result_o, crc_poly_o, crc_size_o, m_res, m_poly, m_size;
  logic m_rev;
  logic [31:0] exp_q[$];
  int errors, checked;
  logic [15:0] lsw_tab [20] = '{16'hE524, 16'hBF00, 16'hBD00, 16'hE2CB, 16'hE2CB, 16'hE754, 16'hE755, 16'hE2CB,
    16'hE2CB, 16'hE756, 16'hE2CB, 16'hE2CB, 16'hE52E, 16'hE3F2, 16'hE3F2, 16'hE206, 16'hE206, 16'hE52C, 16'hE52D,
    16'hE2CB};
  logic [7:0] sel_tab [20] = '{8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h02, 8'hFF, 8'hFF, 8'h05, 8'h04, 8'hFF, 8'h06, 8'h07,
    8'hFF, 8'h00, 8'h02, 8'h01, 8'h02, 8'hFF, 8'hFF, 8'h03};

  crc_coprocessor_unit dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_ready_o(op_ready_o),
    .op_lsw_i(op_lsw_i), .op_msw_i(op_msw_i), .op_data_i(op_data_i), .op_done_o(op_done_o), .st_valid_o(st_valid_o),
    .st_ready_i(st_ready_i), .st_data_o(st_data_o), .crc_result_o(crc_result_o), .crc_poly_o(crc_poly_o),
    .crc_size_o(crc_size_o), .msg_bit_reverse_o(msg_bit_reverse_o), .busy_o(busy_o));
  crc_store_sink u_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .st_valid_i(st_valid_o), .st_data_i(st_data_o),
    .stall_i(stall), .st_ready_o(st_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ------------------------------
  // Expectations
  // ------------------------------
  function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] p, logic [4:0] pw, logic [2:0] dw,
      logic [15:0] w, int base, logic flip);
    logic [31:0] mask;
    logic [31:0] lo;
    mask = (pw == 5'h1F) ? 32'hFFFFFFFF : ((32'h1 << (pw + 1)) - 32'h1);
    for (int i = 0; i <= dw; i++) begin
      lo = (c & mask) << 1;
      if (c[pw] ^ (flip ? w[base + i] : w[base + dw - i])) lo = lo ^ p;
      c = (c & ~mask) | (lo & mask);
    end
    return c;
  endfunction : fold

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("Counts: %0d compared, %0d mismatched", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic model(int k, logic [15:0] m, logic [31:0] d, output int lat);
    lat = 1;
    case (k)
      0: m_res = 32'h0;
      1: begin exp_q.push_back(m_res); lat = 2; end
      2: begin m_res = d; lat = 2; end
      3: m_res = fold(m_res, 32'h005D6DCB, 5'h17, 3'h7, d[15:0], 0, m_rev);
      4: m_res = fold(m_res, 32'h005D6DCB, 5'h17, 3'h7, d[15:0], 8, m_rev);
      5: m_poly = {16'h0000, m};
      6: m_poly[31:16] = m;
      7: m_size[31:16] = d[15:0];
      8: m_size[15:0] = d[15:0];
      9: m_size = {13'h0, m[10:8], 11'h0, m[4:0]};
      10: begin m_res = fold(m_res, m_poly, m_size[4:0], m_size[18:16], d[15:0], 0, m_rev); lat = 3; end
      11: begin m_res = fold(m_res, m_poly, m_size[4:0], m_size[18:16], d[15:0], 8, m_rev); lat = 3; end
      12: m_res[15:0] = {m_res[7:0], m_res[15:8]};
      13: m_poly = d;
      14: m_size = d;
      15: exp_q.push_back(m_poly);
      16: exp_q.push_back(m_size);
      17: m_rev = 1'b1;
      18: m_rev = 1'b0;
      default: lat = 1;
    endcase
  endtask : model

  // ------------------------------
  // Instruction driver, entered at a falling edge
  // ------------------------------
  task automatic do_op(int k, logic [15:0] m, logic [31:0] d);
    int lat;
    int n;
    op_lsw_i = (k == 1 || k == 2) ? {lsw_tab[k][15:8], m[15:8]} : lsw_tab[k];
    op_msw_i = (sel_tab[k] == 8'hFF) ? m : {sel_tab[k], m[7:0]};
    op_data_i = d;
    op_valid_i = 1'b1;
    n = 0;
    #1;
    while (op_ready_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      #1;
      n++;
    end
    if (n == 200) begin
      errors++;
      end_sim();
    end
    @(posedge clk_i);
    @(negedge clk_i);
    op_valid_i = 1'b0;
    model(k, op_msw_i, d, lat);
    n = 1;
    while (op_done_o !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    check("latency", lat, n);
    if (n == 10) end_sim();
    check("result", m_res, crc_result_o);
    check("poly", m_poly, crc_poly_o);
    check("size", m_size, crc_size_o);
    check("reverse", {31'h0, m_rev}, {31'h0, msg_bit_reverse_o});
    @(negedge clk_i);
  endtask : do_op

  task automatic drain();
    int n;
    n = 0;
    while (u_sink.got.size() < exp_q.size() && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    check("store count", exp_q.size(), u_sink.got.size());
    if (n == 500) begin
      errors++;
      end_sim();
    end
    while (exp_q.size() > 0 && u_sink.got.size() > 0) begin
      check("store word", exp_q.pop_front(), u_sink.got.pop_front());
    end
    exp_q.delete();
    u_sink.got.delete();
    check("store empty", 32'h0, {31'h0, st_valid_o});
  endtask : drain

  task automatic do_reset();
    rst_n_i = 1'b0;
    m_res = 32'h0;
    m_poly = 32'h0;
    m_size = 32'h0;
    m_rev = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    check("reset regs", 32'h0, crc_result_o | crc_poly_o | crc_size_o);
    check("reset flags", 32'h1, {27'h0, busy_o, op_done_o, st_valid_o, msg_bit_reverse_o, op_ready_o});
  endtask : do_reset

  initial begin
    errors = 0;
    checked = 0;
    op_valid_i = 1'b0;
    op_lsw_i = 16'h0000;
    op_msw_i = 16'h0000;
    op_data_i = 32'h0;
    stall = 1'b0;
    void'($urandom(8));
    do_reset();
    for (int k = 0; k < 20; k++) do_op(k, 16'($urandom), $urandom);
    drain();
    $display("TEST every_kind done");
    do_op(17, 16'h0, 32'h0);
    do_op(9, 16'h001F, 32'h0);
    do_op(13, 16'h0, 32'h04C11DB7);
    do_op(2, 16'h0, 32'hFFFFFFFF);
    do_op(11, 16'h0, 32'h0000A5C3);
    do_op(9, 16'h0700, 32'h0);
    do_op(10, 16'h0, 32'h00000081);
    do_op(3, 16'h0, 32'h000000C5);
    do_op(18, 16'h0, 32'h0);
    do_op(4, 16'h0, 32'h00008100);
    do_op(12, 16'h0, 32'h0);
    $display("TEST width_corners done");
    repeat (300) do_op($urandom_range(19), 16'($urandom), $urandom);
    drain();
    $display("TEST random_ops done");
    stall = 1'b1;
    repeat (8) do_op(15, 16'h0, 32'h0);
    fork
      do_op(1, 16'($urandom), 32'h0);
      begin
        repeat (5) @(negedge clk_i);
        check("full refusal", 32'h0, {31'h0, op_ready_o});
        stall = 1'b0;
      end
    join
    drain();
    $display("TEST store_full done");
    do_op(2, 16'h0, 32'h12345678);
    do_reset();
    do_op(0, 16'h0, 32'h0);
    $display("TEST mid_reset done");
    end_sim();
  end
endmodule : test_crc_coprocessor_unit

`default_nettype wire
